// >>> pma_defines.svh
// Power monitor accumulator: register offsets, field positions, reset values.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
`ifndef PMA_DEFINES_SVH
`define PMA_DEFINES_SVH
`define PMA_OFS_CFG 8'h00
`define PMA_OFS_CTL 8'h04
`define PMA_OFS_CUR 8'h08
`define PMA_OFS_VIN 8'h0c
`define PMA_OFS_AUX 8'h10
`define PMA_OFS_PWR 8'h14
`define PMA_OFS_EACC 8'h18
`define PMA_OFS_ECNT 8'h1c
`define PMA_OFS_PK_I 8'h20
`define PMA_OFS_PK_V 8'h24
`define PMA_OFS_PK_A 8'h28
`define PMA_CFG_SINGLE 0
`define PMA_CFG_EXP_LSB 1
`define PMA_CFG_EXP_MSB 3
`define PMA_CFG_RANGE 4
`define PMA_CFG_AUX 5
`define PMA_CFG_EXT 6
`define PMA_CTL_EXTERNAL_TRIGGER_MODE 0
`define PMA_CTL_GROUP 1
`define PMA_CFG_RST 7'h00
`define PMA_I_MIN 12'h800
`define PMA_V_MIN 12'h000
`define PMA_CH_I 2'h0
`define PMA_CH_V 2'h1
`define PMA_CH_A 2'h2
`endif

// >>> pma_pkg.sv
// Power monitor accumulator: shared types.
// Assumes pma_defines.svh for all numbers.
package pma_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_SUM} pma_st_type;
  typedef struct packed {
    logic [23:0] power;
    logic [23:0] acc;
    logic [7:0] roll;
    logic [23:0] count;
  } pma_energy_type;
  typedef struct packed {
    logic [2:0][11:0] pk;
  } pma_peak_type;
endpackage

// >>> pma_meas_if.sv
// Measurement carrier between the sequencer and its energy and peak units.
// Assumes one clock domain shared by all parties.
`timescale 1ns/10ps
interface pma_meas_if;
  logic valid;
  logic [11:0] cur;
  logic [11:0] volt;
  logic [11:0] aux;
  logic aux_ok;
  logic [2:0] clr;
  logic [2:0][11:0] pk;
  modport src (output valid, output cur, output volt, output aux, output aux_ok, output clr, input pk);
  modport energy (input valid, input cur, input volt);
  modport peak (input valid, input cur, input volt, input aux, input aux_ok, input clr, output pk);
endinterface

// >>> pma_energy.sv
// Power product, energy accumulator, rollover and sample counters.
// Assumes valid pulses one cycle per paired current and voltage sample.
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_energy import pma_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  pma_meas_if.energy m,
  output logic [23:0] power,
  output logic [23:0] acc,
  output logic [7:0] roll,
  output logic [23:0] count
);
  pma_energy_type r, n;
  logic signed [24:0] prod;
  logic [24:0] sum;
  logic [23:0] pw;

  always_comb begin
    n = r;
    prod = $signed(m.cur) * $signed({1'b0, m.volt});
    // Negative power is not accumulated as energy
    pw = prod[24] ? 24'h000000 : prod[23:0];
    sum = {1'b0, r.acc} + {1'b0, pw};
    if (m.valid) begin
      n.power = pw;
      n.acc = sum[23:0];
      if (sum[24]) begin
        n.roll = r.roll + 8'h01;
      end
      n.count = r.count + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign power = r.power;
  assign acc = r.acc;
  assign roll = r.roll;
  assign count = r.count;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_count_step: assert property (m.valid |=> r.count == $past(r.count) + 24'h000001)
    else $error("sample count did not step");
  a_roll_carry: assert property (m.valid && sum[24] |=> r.roll == $past(r.roll) + 8'h01)
    else $error("rollover not counted");
  a_power_hold: assert property (!m.valid |=> $stable(r.power) && $stable(r.acc))
    else $error("power changed without a sample");
  c_rollover: cover property (m.valid && sum[24]);
endmodule // pma_energy

// >>> pma_peak.sv
// Peak trackers for current, input voltage and auxiliary voltage.
// Assumes clear pulses and samples arrive on the same clock.
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_peak import pma_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  pma_meas_if.peak m
);
  pma_peak_type r, n;
  logic [2:0][11:0] smp;
  logic [2:0] upd;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ch
      logic [11:0] key_new;
      logic [11:0] key_old;
      // Current is signed: flipping the sign bit orders it as unsigned
      assign smp[g] = (g == 0) ? m.cur : ((g == 1) ? m.volt : m.aux);
      assign key_new = (g == 0) ? {~smp[g][11], smp[g][10:0]} : smp[g];
      assign key_old = (g == 0) ? {~r.pk[g][11], r.pk[g][10:0]} : r.pk[g];
      assign upd[g] = m.valid && (g != 2 || m.aux_ok) && (key_new > key_old);
    end
  endgenerate

  always_comb begin
    n = r;
    for (int i = 0; i < 3; i++) begin
      if (m.clr[i]) begin
        n.pk[i] = (i == 0) ? `PMA_I_MIN : `PMA_V_MIN;
      end
      // A sample in the clear cycle still counts
      if (upd[i] || (m.clr[i] && m.valid && (i != 2 || m.aux_ok))) begin
        n.pk[i] = smp[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r.pk[0] <= `PMA_I_MIN;
      r.pk[1] <= `PMA_V_MIN;
      r.pk[2] <= `PMA_V_MIN;
    end else begin
      r <= n;
    end
  end

  assign m.pk = r.pk;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_peak_rise: assert property (upd[1] |=> r.pk[1] == $past(m.volt))
    else $error("voltage peak not taken");
  a_peak_clear: assert property (m.clr[0] && !m.valid |=> r.pk[0] == `PMA_I_MIN)
    else $error("current peak not cleared to minimum");
endmodule // pma_peak

// >>> pma_top.sv
// Power monitor sequencer with APB registers, averaging and result publishing.
// Assumes an ADC handshake on clk_sys and a bus stop pulse from the bus front end.
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_top import pma_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_stop,
  input wire logic multifunction_output_pin,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic adc_start,
  output logic [1:0] adc_chan,
  output logic sense_range_wide
);
  typedef struct packed {
    pma_st_type st;
    logic [1:0] chan;
    logic single;
    logic [2:0] avg_exp;
    logic range_wide;
    logic aux_en;
    logic ext_mode;
    logic hold_pend;
    logic [2:0] pin_sync;
    logic [7:0] cnt;
    logic [19:0] sum_i;
    logic [19:0] sum_v;
    logic [19:0] sum_a;
    logic [11:0] smp_i;
    logic [11:0] smp_v;
    logic [11:0] smp_a;
    logic smp_aux;
    logic smp_valid;
    logic [11:0] res_i;
    logic [11:0] res_v;
    logic [11:0] res_a;
    logic [23:0] snap_cnt;
    logic [31:0] rdata;
  } pma_core_type;

  pma_core_type r, n;
  pma_meas_if meas ();
  logic [23:0] power;
  logic [23:0] acc;
  logic [7:0] roll;
  logic [23:0] count;
  logic ext_rise;
  logic wr;
  logic rd_setup;
  logic external_trigger_mode_wr;
  logic trig;
  logic publish;
  logic hit;
  logic [8:0] target;
  logic [19:0] si_new;
  logic [19:0] sv_new;
  logic [19:0] sa_new;
  logic [2:0] clr;

  pma_energy u_energy (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .m(meas),
    .power(power),
    .acc(acc),
    .roll(roll),
    .count(count)
  );

  pma_peak u_peak (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .m(meas)
  );

  always_comb begin
    n = r;
    n.smp_valid = 1'b0;
    // Edge detect reads only the second and third stages
    n.pin_sync = {r.pin_sync[1:0], multifunction_output_pin};
    ext_rise = r.pin_sync[1] & ~r.pin_sync[2];
    wr = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    external_trigger_mode_wr = wr && (paddr == `PMA_OFS_CTL) && pwdata[`PMA_CTL_EXTERNAL_TRIGGER_MODE];
    trig = r.single && (r.st == ST_IDLE) && ((external_trigger_mode_wr && !pwdata[`PMA_CTL_GROUP])
      || (r.hold_pend && bus_stop)
      || (r.ext_mode && ext_rise));
    target = 9'h001 << r.avg_exp;
    publish = ({1'b0, r.cnt} + 9'h001) >= target;
    si_new = r.sum_i + {{8{r.smp_i[11]}}, r.smp_i};
    sv_new = r.sum_v + {8'h00, r.smp_v};
    sa_new = r.sum_a + (r.smp_aux ? {8'h00, r.smp_a} : 20'h00000);
    clr = 3'h0;
    // Stop ends any held group convert; a new held convert wins over it
    if (bus_stop) begin
      n.hold_pend = 1'b0;
    end
    if (external_trigger_mode_wr && pwdata[`PMA_CTL_GROUP]) begin
      n.hold_pend = 1'b1;
    end
    if (wr && paddr == `PMA_OFS_CFG) begin
      n.single = pwdata[`PMA_CFG_SINGLE];
      n.avg_exp = pwdata[`PMA_CFG_EXP_MSB:`PMA_CFG_EXP_LSB];
      n.range_wide = pwdata[`PMA_CFG_RANGE];
      n.aux_en = pwdata[`PMA_CFG_AUX];
      n.ext_mode = pwdata[`PMA_CFG_EXT];
    end
    if (wr) begin
      clr[0] = paddr == `PMA_OFS_PK_I;
      clr[1] = paddr == `PMA_OFS_PK_V;
      clr[2] = paddr == `PMA_OFS_PK_A;
    end
    case (r.st)
      ST_IDLE: begin
        // Continuous mode restarts by itself; single shot waits
        if (trig || !r.single) begin
          n.st = ST_START;
          n.chan = `PMA_CH_I;
        end
      end
      ST_START: begin
        n.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (adc_done) begin
          case (r.chan)
            `PMA_CH_I: begin
              n.smp_i = adc_result;
              n.chan = `PMA_CH_V;
              n.st = ST_START;
            end
            `PMA_CH_V: begin
              n.smp_v = adc_result;
              n.smp_aux = 1'b0;
              if (r.aux_en) begin
                n.chan = `PMA_CH_A;
                n.st = ST_START;
              end else begin
                n.st = ST_SUM;
              end
            end
            default: begin
              n.smp_a = adc_result;
              n.smp_aux = 1'b1;
              n.st = ST_SUM;
            end
          endcase
        end
      end
      ST_SUM: begin
        n.smp_valid = 1'b1;
        n.chan = `PMA_CH_I;
        if (publish) begin
          // Averages fit twelve bits, so the low part of the shift is exact
          n.res_i = 12'($signed(si_new) >>> r.avg_exp);
          n.res_v = 12'(sv_new >> r.avg_exp);
          n.res_a = 12'(sa_new >> r.avg_exp);
          n.sum_i = 20'h00000;
          n.sum_v = 20'h00000;
          n.sum_a = 20'h00000;
          n.cnt = 8'h00;
          n.st = r.single ? ST_IDLE : ST_START;
        end else begin
          n.sum_i = si_new;
          n.sum_v = sv_new;
          n.sum_a = sa_new;
          n.cnt = r.cnt + 8'h01;
          n.st = ST_START;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    hit = 1'b1;
    if (rd_setup) begin
      case (paddr)
        `PMA_OFS_CFG: n.rdata = {25'h0000000, r.ext_mode, r.aux_en, r.range_wide, r.avg_exp, r.single};
        `PMA_OFS_CTL: n.rdata = {30'h00000000, r.hold_pend, r.st != ST_IDLE};
        `PMA_OFS_CUR: n.rdata = {{20{r.res_i[11]}}, r.res_i};
        `PMA_OFS_VIN: n.rdata = {20'h00000, r.res_v};
        `PMA_OFS_AUX: n.rdata = {20'h00000, r.res_a};
        `PMA_OFS_PWR: n.rdata = {8'h00, power};
        `PMA_OFS_EACC: begin
          n.rdata = {roll, acc};
          n.snap_cnt = count;
        end
        `PMA_OFS_ECNT: n.rdata = {8'h00, r.snap_cnt};
        `PMA_OFS_PK_I: n.rdata = {{20{meas.pk[0][11]}}, meas.pk[0]};
        `PMA_OFS_PK_V: n.rdata = {20'h00000, meas.pk[1]};
        `PMA_OFS_PK_A: n.rdata = {20'h00000, meas.pk[2]};
        default: n.rdata = 32'h00000000;
      endcase
    end
    case (paddr)
      `PMA_OFS_CFG, `PMA_OFS_CTL, `PMA_OFS_CUR, `PMA_OFS_VIN, `PMA_OFS_AUX, `PMA_OFS_PWR,
      `PMA_OFS_EACC, `PMA_OFS_ECNT, `PMA_OFS_PK_I, `PMA_OFS_PK_V, `PMA_OFS_PK_A: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.single <= 1'(`PMA_CFG_RST >> `PMA_CFG_SINGLE);
    end else begin
      r <= n;
    end
  end

  assign meas.valid = r.smp_valid;
  assign meas.cur = r.smp_i;
  assign meas.volt = r.smp_v;
  assign meas.aux = r.smp_a;
  assign meas.aux_ok = r.smp_aux;
  assign meas.clr = clr;

  // Zero wait states: read data is latched in the setup cycle
  assign prdata = r.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign adc_start = r.st == ST_START;
  assign adc_chan = r.chan;
  assign sense_range_wide = r.range_wide;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_aux_only_enabled: assert property (adc_start && adc_chan == `PMA_CH_A |-> r.aux_en)
    else $error("aux converted while disabled");
  a_cont_restart: assert property (r.st == ST_IDLE && !r.single |=> r.st == ST_START)
    else $error("continuous mode did not restart");
  a_sw_start: assert property (trig && external_trigger_mode_wr |=> r.st == ST_START ##1 adc_start == 1'b0)
    else $error("software convert did not start sampling");
  a_group_wait: assert property (r.hold_pend && !bus_stop && r.single && r.st == ST_IDLE
    && !external_trigger_mode_wr && !(r.ext_mode && ext_rise) |=> r.st == ST_IDLE)
    else $error("group convert started before stop");
  a_ext_trig: assert property (r.single && r.ext_mode && ext_rise && r.st == ST_IDLE |=> r.st == ST_START)
    else $error("external trigger ignored");
  a_single_idle: assert property (r.st == ST_SUM && publish && r.single |=> r.st == ST_IDLE)
    else $error("single shot did not return to idle");
  a_avg_count: assert property (r.st == ST_SUM && publish |-> ({1'b0, r.cnt} + 9'h001) == target
    || $past(r.avg_exp) != r.avg_exp || r.cnt >= target[7:0])
    else $error("average published at wrong count");
  a_snap_pair: assert property (rd_setup && paddr == `PMA_OFS_EACC |=> r.snap_cnt == $past(count)
    && r.rdata[23:0] == $past(acc))
    else $error("energy snapshot not paired");
  a_pair_valid: assert property (r.st == ST_SUM |=> meas.valid ##1 !meas.valid)
    else $error("power pair not delivered once");
  a_cfg_single: assert property (wr && paddr == `PMA_OFS_CFG
    |=> r.single == $past(pwdata[`PMA_CFG_SINGLE]))
    else $error("single mode bit not taken");
  a_cfg_exp: assert property (wr && paddr == `PMA_OFS_CFG
    |=> r.avg_exp == $past(pwdata[`PMA_CFG_EXP_MSB:`PMA_CFG_EXP_LSB]))
    else $error("averaging exponent not taken");
  a_range_take: assert property (wr && paddr == `PMA_OFS_CFG
    |=> sense_range_wide == $past(pwdata[`PMA_CFG_RANGE]))
    else $error("sense range not taken");
  a_range_hold: assert property (!(wr && paddr == `PMA_OFS_CFG)
    |=> $stable(sense_range_wide))
    else $error("sense range changed without a write");
  a_hold_set: assert property (external_trigger_mode_wr && pwdata[`PMA_CTL_GROUP]
    |=> r.hold_pend)
    else $error("group convert not held");
  a_hold_drop: assert property (r.hold_pend && bus_stop && !(external_trigger_mode_wr && pwdata[`PMA_CTL_GROUP])
    |=> !r.hold_pend)
    else $error("held convert kept after stop");
  a_group_fire: assert property (r.hold_pend && bus_stop && r.single && r.st == ST_IDLE
    |=> r.st == ST_START)
    else $error("stop did not start held convert");
  a_held_no_start: assert property (external_trigger_mode_wr && pwdata[`PMA_CTL_GROUP] && !bus_stop && r.single
    && r.st == ST_IDLE && !(r.ext_mode && ext_rise) |=> r.st == ST_IDLE)
    else $error("group convert started at once");
  a_pin_ignored: assert property (r.single && r.st == ST_IDLE && !r.ext_mode && !external_trigger_mode_wr
    && !(r.hold_pend && bus_stop) |=> r.st == ST_IDLE)
    else $error("pin started a shot outside trigger mode");
  a_shot_rest: assert property (r.single && r.st == ST_IDLE && !trig
    |=> !adc_start)
    else $error("conversion without a trigger");
  a_i_then_v: assert property (r.st == ST_WAIT && adc_done && r.chan == `PMA_CH_I
    |=> adc_start && adc_chan == `PMA_CH_V)
    else $error("voltage did not follow current");
  a_aux_skip: assert property (r.st == ST_WAIT && adc_done && r.chan == `PMA_CH_V && !r.aux_en
    |=> r.st == ST_SUM)
    else $error("aux slot not skipped");
  a_aux_next: assert property (r.st == ST_WAIT && adc_done && r.chan == `PMA_CH_V && r.aux_en
    |=> adc_start && adc_chan == `PMA_CH_A)
    else $error("aux did not follow voltage");
  a_cnt_step: assert property (r.st == ST_SUM && !publish
    |=> r.cnt == $past(r.cnt) + 8'h01)
    else $error("average count did not step");
  a_block_clear: assert property (r.st == ST_SUM && publish
    |=> r.cnt == 8'h00 && r.sum_v == 20'h00000)
    else $error("average block not restarted");
  a_cont_loop: assert property (r.st == ST_SUM && publish && !r.single
    |=> r.st == ST_START)
    else $error("continuous mode stopped after a result");
  a_snap_hold: assert property (!(rd_setup && paddr == `PMA_OFS_EACC)
    |=> $stable(r.snap_cnt))
    else $error("sample snapshot moved without an energy read");
  a_power_read: assert property (rd_setup && paddr == `PMA_OFS_PWR
    |=> prdata == {8'h00, $past(power)})
    else $error("power read does not match product");
  a_cur_signed: assert property (rd_setup && paddr == `PMA_OFS_CUR
    |=> prdata[31:12] == {20{prdata[11]}})
    else $error("current read not sign extended");
  a_clear_pulse: assert property (wr && paddr == `PMA_OFS_PK_I
    |-> meas.clr == 3'h1)
    else $error("current peak clear not issued");
  a_peak_read: assert property (rd_setup && paddr == `PMA_OFS_PK_V
    |=> prdata == {20'h00000, $past(meas.pk[1])})
    else $error("voltage peak read mismatch");
  a_res_hold: assert property (!(r.st == ST_SUM && publish)
    |=> $stable(r.res_i) && $stable(r.res_v))
    else $error("result changed between publishes");
  c_single_done: cover property (r.single && r.st == ST_SUM && publish);
  c_group_fire: cover property (r.hold_pend && bus_stop && trig);
  c_ext_fire: cover property (r.ext_mode && ext_rise && trig);
  c_avg_max: cover property (r.st == ST_SUM && publish && r.avg_exp == 3'h7);
endmodule // pma_top

// >>> pma_adc_model.sv
// Behavioural ADC on the far side of the sequencer's conversion handshake.
// Assumes adc_start pulses one cycle with adc_chan valid, all on clk_sys.
`timescale 1ns/10ps
module pma_adc_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  input wire logic slow,
  input wire logic alt,
  input wire logic [11:0] cur_code,
  input wire logic [11:0] volt_code,
  input wire logic [11:0] aux_code,
  output logic adc_done,
  output logic [11:0] adc_result
);
  logic busy;
  logic flip;
  logic [1:0] ch;
  logic [3:0] cnt;
  logic [11:0] value;
  always_comb begin
    case (ch)
      2'h0: value = cur_code + ((alt && flip) ? 12'h008 : 12'h000);
      2'h1: value = volt_code;
      default: value = aux_code;
    endcase
  end
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      flip <= 1'b0;
      ch <= 2'h0;
      cnt <= 4'h0;
      adc_done <= 1'b0;
      adc_result <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      // Result bus is not held outside the done pulse
      adc_result <= ~adc_result;
      if (adc_start) begin
        busy <= 1'b1;
        ch <= adc_chan;
        cnt <= slow ? 4'h6 : 4'h0;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_result <= value;
        if (ch == 2'h0) begin
          flip <= ~flip;
        end
      end
    end
  end
endmodule // pma_adc_model

// >>> pma_top_bench.sv
// Self-checking bench for the power monitor sequencer over APB.
// Assumes pma_adc_model answers conversions; bench drives pins and bus.
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_top_bench import pma_pkg::*;;
  logic clk_sys, rst_b, psel, penable, pwrite, bus_stop, pin, slow, alt;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, e0, c0;
  logic pready, pslverr, er, adc_done, adc_start, wide;
  logic [11:0] adc_result, cur, volt, aux;
  logic [1:0] adc_chan;
  int n_fail, samples_checked, n_start, n_aux;
  pma_top u_pma_top (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_stop(bus_stop), .multifunction_output_pin(pin),
    .adc_done(adc_done), .adc_result(adc_result), .adc_start(adc_start),
    .adc_chan(adc_chan), .sense_range_wide(wide));
  pma_adc_model u_pma_adc_model (.clk_sys(clk_sys), .rst_b(rst_b), .adc_start(adc_start),
    .adc_chan(adc_chan), .slow(slow), .alt(alt), .cur_code(cur), .volt_code(volt),
    .aux_code(aux), .adc_done(adc_done), .adc_result(adc_result));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (adc_start === 1'b1) begin
      n_start++;
      if (adc_chan === 2'h2) n_aux++;
    end
  end
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Called just after a rising edge; returns one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic idle();
    for (int k = 0; k < 200; k++) begin
      apb(1'b0, `PMA_OFS_CTL, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic t_defaults();
    apb(1'b0, `PMA_OFS_CFG, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, wide}, 32'h0);
    repeat (100) @(posedge clk_sys);
    chk({31'h0, n_start > 20}, 32'h1);
    apb(1'b0, `PMA_OFS_CUR, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd100);
    apb(1'b0, `PMA_OFS_PWR, 32'h0);
    chk({8'h0, rd[23:0]}, 32'd20000);
    apb(1'b0, `PMA_OFS_EACC, 32'h0);
    e0 = rd;
    repeat (40) @(posedge clk_sys);
    apb(1'b0, `PMA_OFS_ECNT, 32'h0);
    chk(e0, rd * 32'd20000);
    chk(n_aux, 32'h0);
  endtask
  task automatic t_negative();
    cur <= 12'hf9c;
    slow <= 1'b1;
    repeat (100) @(posedge clk_sys);
    apb(1'b0, `PMA_OFS_CUR, 32'h0);
    chk({20'h0, rd[11:0]}, 32'h00000f9c);
    apb(1'b0, `PMA_OFS_PWR, 32'h0);
    chk({8'h0, rd[23:0]}, 32'h0);
  endtask
  task automatic t_single();
    apb(1'b1, `PMA_OFS_CFG, 32'h07);
    idle();
    cur <= 12'd2032;
    volt <= 12'd4095;
    alt <= 1'b1;
    apb(1'b0, `PMA_OFS_EACC, 32'h0);
    e0 = rd;
    apb(1'b0, `PMA_OFS_ECNT, 32'h0);
    c0 = rd;
    n_start = 0;
    apb(1'b1, `PMA_OFS_CTL, 32'h1);
    idle();
    chk(n_start, 32'd16);
    repeat (60) @(posedge clk_sys);
    chk(n_start, 32'd16);
    apb(1'b0, `PMA_OFS_CUR, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd2036);
    apb(1'b0, `PMA_OFS_VIN, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd4095);
    apb(1'b0, `PMA_OFS_EACC, 32'h0);
    // Sum passes 2^24, so the rollover byte must move
    chk(rd - e0, 32'd4 * (32'd2032 * 32'd4095 + 32'd2040 * 32'd4095));
    apb(1'b0, `PMA_OFS_ECNT, 32'h0);
    chk(rd - c0, 32'd8);
  endtask
  task automatic t_peaks();
    apb(1'b1, `PMA_OFS_PK_I, 32'h0);
    apb(1'b1, `PMA_OFS_PK_V, 32'h0);
    apb(1'b0, `PMA_OFS_PK_I, 32'h0);
    chk({20'h0, rd[11:0]}, 32'h800);
    apb(1'b0, `PMA_OFS_PK_V, 32'h0);
    chk({20'h0, rd[11:0]}, 32'h0);
    cur <= 12'd300;
    volt <= 12'd1000;
    apb(1'b1, `PMA_OFS_CFG, 32'h33);
    chk({31'h0, wide}, 32'h1);
    n_start = 0;
    n_aux = 0;
    apb(1'b1, `PMA_OFS_CTL, 32'h1);
    idle();
    chk(n_start, 32'd6);
    chk(n_aux, 32'd2);
    apb(1'b0, `PMA_OFS_PK_I, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd308);
    apb(1'b0, `PMA_OFS_PK_V, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd1000);
    apb(1'b0, `PMA_OFS_AUX, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd50);
    apb(1'b0, `PMA_OFS_PK_A, 32'h0);
    chk({20'h0, rd[11:0]}, 32'd50);
  endtask
  task automatic t_triggers();
    apb(1'b1, `PMA_OFS_CFG, 32'h01);
    n_start = 0;
    apb(1'b1, `PMA_OFS_CTL, 32'h3);
    repeat (30) @(posedge clk_sys);
    chk(n_start, 32'd0);
    bus_stop <= 1'b1;
    @(posedge clk_sys);
    bus_stop <= 1'b0;
    idle();
    chk(n_start, 32'd2);
    apb(1'b1, `PMA_OFS_CFG, 32'h41);
    n_start = 0;
    pin <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(n_start, 32'd2);
    pin <= 1'b0;
  endtask
  task automatic t_unmapped();
    apb(1'b1, 8'h40, 32'h7f);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, `PMA_OFS_CFG, 32'h0);
    chk({25'h0, rd[6:0]}, 32'h41);
  endtask
  initial begin
    // Watchdog sized well past the roughly one thousand cycles the tests need
    #200000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {rst_b, psel, penable, pwrite, bus_stop, pin, slow, alt} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cur = 12'd100;
    volt = 12'd200;
    aux = 12'd50;
    n_fail = 0;
    samples_checked = 0;
    n_start = 0;
    n_aux = 0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_defaults();
    t_negative();
    t_single();
    t_peaks();
    t_triggers();
    t_unmapped();
    wrap_up();
  end
endmodule // pma_top_bench
